// file: cbu_regs.vh
// Constants of the conditional branch unit
`ifndef CBU_REGS_VH
`define CBU_REGS_VH
// ----------------------------------------
// Branch selector encodings
// ----------------------------------------
`define CBU_SEL_W            4
`define CBU_SEL_LOWER        4'h0
`define CBU_SEL_SAME_HIGHER  4'h1
`define CBU_SEL_NEGATIVE     4'h2
`define CBU_SEL_POSITIVE     4'h3
`define CBU_SEL_SIGNED_GE    4'h4
`define CBU_SEL_SIGNED_LT    4'h5
`define CBU_SEL_HALF_SET     4'h6
`define CBU_SEL_HALF_CLEAR   4'h7
`define CBU_SEL_BIT_SET      4'h8
// ----------------------------------------
// Status flag positions
// ----------------------------------------
`define CBU_FLAG_C           0
`define CBU_FLAG_N           2
`define CBU_FLAG_V           3
`define CBU_FLAG_H           5
`define CBU_FLAG_T           6
`define CBU_SREG_W           8
// ----------------------------------------
// Widths and timing
// ----------------------------------------
`define CBU_PC_W             16
`define CBU_OFS_W            7
`define CBU_PC_RESET         16'h0000
`define CBU_TAKEN_CYCLES     2'h2
`endif

// file: cbu_cond.v
// Condition evaluator for the conditional branch unit
`timescale 1ns/1ps
`include "cbu_regs.vh"
module cbu_cond (
    input  wire [`CBU_SEL_W-1:0]  sel,
    input  wire [`CBU_SREG_W-1:0] sreg,
    output reg                    cond
);
    wire c = sreg[`CBU_FLAG_C];
    wire n = sreg[`CBU_FLAG_N];
    wire v = sreg[`CBU_FLAG_V];
    wire h = sreg[`CBU_FLAG_H];
    wire t = sreg[`CBU_FLAG_T];
    // Select the flag test for each branch kind
    always @* begin
        case (sel)
            `CBU_SEL_LOWER:       cond = c;
            `CBU_SEL_SAME_HIGHER: cond = ~c;
            `CBU_SEL_NEGATIVE:    cond = n;
            `CBU_SEL_POSITIVE:    cond = ~n;
            `CBU_SEL_SIGNED_GE:   cond = ~(n ^ v);
            `CBU_SEL_SIGNED_LT:   cond = n ^ v;
            `CBU_SEL_HALF_SET:    cond = h;
            `CBU_SEL_HALF_CLEAR:  cond = ~h;
            `CBU_SEL_BIT_SET:     cond = t;
            default:              cond = 1'b0;
        endcase
    end
endmodule

// file: cbu_branch_unit.v
// Conditional relative branch unit of the 8-bit core
`timescale 1ns/1ps
`include "cbu_regs.vh"
// Operation
// - branch_if_lower jumps to pc+offset+1 when carry is one
// - same-or-higher branch jumps when carry is zero
// - branch_if_negative jumps when negative flag is one
// - branch_if_positive jumps when negative flag is zero
// - branch_if_signed_ge jumps when negative xor overflow is zero
// - branch_if_signed_lt jumps when negative xor overflow is one
// - branch_if_half_carry_set jumps when half-carry is one
// - branch_if_half_carry_clear jumps when half-carry is zero
// - branch_if_bit_flag_set jumps when bit-transfer flag is set
// - every branch completes in one or two cycles
// - no status flag is changed by any branch
module cbu_branch_unit #(
    parameter PC_W  = `CBU_PC_W,
    parameter OFS_W = `CBU_OFS_W
) (
    input  wire                    sys_clk,
    input  wire                    rst_b,
    input  wire                    exec_valid,
    input  wire [`CBU_SEL_W-1:0]   branch_sel,
    input  wire [OFS_W-1:0]        offset,
    input  wire [PC_W-1:0]         pc_in,
    input  wire [`CBU_SREG_W-1:0]  sreg_in,
    output reg                     pc_load,
    output reg  [PC_W-1:0]         pc_target,
    output reg                     busy,
    output reg                     done,
    output reg                     taken,
    output reg  [`CBU_SREG_W-1:0]  sreg_out
);
    // ----------------------------------------
    // Sequencer states and timing
    // ----------------------------------------
    // Idle waits for an issue; jump is the second cycle of a taken branch
    localparam ST_IDLE = 1'b0;
    localparam ST_JUMP = 1'b1;

    // Width of the cycle counter of a taken branch
    localparam CNT_W   = 2;

    // Counter values; a taken branch ends two cycles after its issue
    localparam [CNT_W-1:0] CNT_LAST = `CBU_TAKEN_CYCLES - 2'h1;
    localparam [CNT_W-1:0] CNT_ONE  = 2'h1;
    localparam [CNT_W-1:0] CNT_ZERO = 2'h0;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    // Sequencer registers
    reg                 state;          // Idle or second cycle
    reg  [CNT_W-1:0]    cyc_cnt;        // Cycles spent in a taken branch

    // Next values of the sequencer and the pulses
    reg                 next_state;
    reg  [CNT_W-1:0]    next_cyc_cnt;
    reg                 next_pc_load;
    reg                 next_busy;
    reg                 next_done;
    reg                 next_taken;

    // Branch kind selects
    wire                sel_lower;
    wire                sel_same_high;
    wire                sel_negative;
    wire                sel_positive;
    wire                sel_signed_ge;
    wire                sel_signed_lt;
    wire                sel_half_set;
    wire                sel_half_clear;
    wire                sel_bit_set;

    // Condition and issue qualifiers
    wire                cond;           // Flag test of the selected kind
    wire                sel_known;      // Selector names a branch kind
    wire                issue;          // Branch accepted this cycle
    wire                issue_taken;    // Accepted and condition holds
    wire                issue_untaken;  // Accepted and condition fails
    wire                cnt_last;       // Final cycle of a taken branch

    // Address arithmetic
    wire [PC_W-1:0]     ofs_ext;        // Offset widened with its sign
    wire [PC_W-1:0]     pc_plus_one;    // Address after the branch
    wire [PC_W-1:0]     next_target;    // Jump destination

    // ----------------------------------------
    // Branch kind decode
    // ----------------------------------------
    // Carry tests
    assign sel_lower      = (branch_sel == `CBU_SEL_LOWER);
    assign sel_same_high  = (branch_sel == `CBU_SEL_SAME_HIGHER);
    // Sign tests
    assign sel_negative   = (branch_sel == `CBU_SEL_NEGATIVE);
    assign sel_positive   = (branch_sel == `CBU_SEL_POSITIVE);
    // Signed comparison tests
    assign sel_signed_ge  = (branch_sel == `CBU_SEL_SIGNED_GE);
    assign sel_signed_lt  = (branch_sel == `CBU_SEL_SIGNED_LT);
    // Half-carry tests
    assign sel_half_set   = (branch_sel == `CBU_SEL_HALF_SET);
    assign sel_half_clear = (branch_sel == `CBU_SEL_HALF_CLEAR);
    // Bit-transfer test
    assign sel_bit_set    = (branch_sel == `CBU_SEL_BIT_SET);

    // Any recognised kind may be taken; other codes never jump
    assign sel_known = sel_lower    | sel_same_high  | sel_negative  |
                       sel_positive | sel_signed_ge  | sel_signed_lt |
                       sel_half_set | sel_half_clear | sel_bit_set;

    // ----------------------------------------
    // Condition evaluator
    // ----------------------------------------
    // Flag test for the selected kind; status flags are only read
    cbu_cond u_cond (
        .sel  (branch_sel),
        .sreg (sreg_in),
        .cond (cond)
    );

    // ----------------------------------------
    // Target address
    // ----------------------------------------
    // Sign-extend the offset to the program counter width
    assign ofs_ext     = {{(PC_W-OFS_W){offset[OFS_W-1]}}, offset};

    // Address of the instruction after the branch
    assign pc_plus_one = pc_in + {{(PC_W-1){1'b0}}, 1'b1};

    // Destination wraps at the program counter width
    assign next_target = pc_plus_one + ofs_ext;

    // ----------------------------------------
    // Issue qualification
    // ----------------------------------------
    // A branch offered during the second cycle of a taken one is ignored
    assign issue         = exec_valid & (state == ST_IDLE);

    // Taken only when the flag test holds for a known kind
    assign issue_taken   = issue & cond & sel_known;
    assign issue_untaken = issue & ~issue_taken;

    // Last cycle of a taken branch reached
    assign cnt_last      = (cyc_cnt == CNT_LAST);

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    // Pulses default low; busy holds unless the state moves
    always @* begin
        next_state   = state;
        next_cyc_cnt = cyc_cnt;
        next_pc_load = 1'b0;
        next_busy    = busy;
        next_done    = 1'b0;
        next_taken   = 1'b0;
        case (state)
            ST_IDLE: begin
                next_cyc_cnt = CNT_ZERO;
                if (issue_taken) begin
                    // Condition holds: add a second cycle
                    next_state   = ST_JUMP;
                    next_cyc_cnt = CNT_ONE;
                    next_busy    = 1'b1;
                end else if (issue_untaken) begin
                    // Condition fails: done pulses in the cycle after the issue
                    next_done    = 1'b1;
                end
            end
            ST_JUMP: begin
                // Count the cycles of the taken branch
                next_cyc_cnt = cyc_cnt + CNT_ONE;
                if (cnt_last) begin
                    // Last cycle: load the program counter and finish
                    next_state   = ST_IDLE;
                    next_cyc_cnt = CNT_ZERO;
                    next_busy    = 1'b0;
                    next_pc_load = 1'b1;
                    next_done    = 1'b1;
                    next_taken   = 1'b1;
                end
            end
            default: begin
                // Unused code: return to idle with nothing pending
                next_state   = ST_IDLE;
                next_cyc_cnt = CNT_ZERO;
                next_busy    = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // Target register
    // ----------------------------------------
    // Holds the last jump destination until the next taken branch
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            pc_target <= `CBU_PC_RESET;
        end else if (issue_taken) begin
            pc_target <= next_target;
        end
    end

    // ----------------------------------------
    // Status flag path
    // ----------------------------------------
    // Flags are passed on one cycle later and never altered by a branch
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            sreg_out <= {`CBU_SREG_W{1'b0}};
        end else begin
            sreg_out <= sreg_in;
        end
    end

    // ----------------------------------------
    // Output registers
    // ----------------------------------------
    // Synchronous reset clears the sequencer and every pulse
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            state   <= ST_IDLE;
            cyc_cnt <= CNT_ZERO;
            pc_load <= 1'b0;
            busy    <= 1'b0;
            done    <= 1'b0;
            taken   <= 1'b0;
        end else begin
            state   <= next_state;
            cyc_cnt <= next_cyc_cnt;
            pc_load <= next_pc_load;
            busy    <= next_busy;
            done    <= next_done;
            taken   <= next_taken;
        end
    end
endmodule

// file: cbu_branch_unit_asserts.sv
// Checker of the conditional branch unit
`timescale 1ns/1ps
module cbu_branch_unit_asserts #(
    parameter PC_W  = 16,
    parameter OFS_W = 7
) (
    input logic             sys_clk,
    input logic             rst_b,
    input logic             exec_valid,
    input logic [3:0]       branch_sel,
    input logic [OFS_W-1:0] offset,
    input logic [PC_W-1:0]  pc_in,
    input logic [7:0]       sreg_in,
    input logic             pc_load,
    input logic [PC_W-1:0]  pc_target,
    input logic             busy,
    input logic             done,
    input logic             taken,
    input logic [7:0]       sreg_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire iss = exec_valid && !busy;
    property p_len; iss |=> busy || done; endproperty
    a_len: assert property (p_len) else $error("no finish");
    property p_two; busy |=> pc_load && done && taken && !busy; endproperty
    a_two: assert property (p_two) else $error("bad end");
    property p_ld; pc_load |-> $past(busy) && taken; endproperty
    a_ld: assert property (p_ld) else $error("stray load");
    property p_fl; iss |=> sreg_out == $past(sreg_in); endproperty
    a_fl: assert property (p_fl) else $error("flags changed");
    property p_lo; iss && branch_sel == 4'h0 && sreg_in[0] |=> busy; endproperty
    a_lo: assert property (p_lo) else $error("lower");
    property p_mi; iss && branch_sel == 4'h2 && !sreg_in[2] |=> !busy;
    endproperty
    a_mi: assert property (p_mi) else $error("negative");
    property p_lt; iss && branch_sel == 4'h5 && (sreg_in[2] ^ sreg_in[3])
        |=> busy; endproperty
    a_lt: assert property (p_lt) else $error("signed lt");
    property p_tg; busy |-> pc_target == $past(pc_in)
        + {{(PC_W-OFS_W){$past(offset[OFS_W-1])}}, $past(offset)}
        + {{(PC_W-1){1'b0}}, 1'b1}; endproperty
    a_tg: assert property (p_tg) else $error("target");
    property p_ts; iss && branch_sel == 4'h8 |=> busy == $past(sreg_in[6]);
    endproperty
    a_ts: assert property (p_ts) else $error("bit flag");
    c_tk: cover property (pc_load);
    c_nt: cover property (done && !taken);
    c_lt: cover property (iss && branch_sel == 4'h5);
    c_rf: cover property (exec_valid && busy);
endmodule
bind cbu_branch_unit cbu_branch_unit_asserts #(
    .PC_W  (PC_W),
    .OFS_W (OFS_W)
) cbu_branch_unit_asserts_i (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .exec_valid (exec_valid),
    .branch_sel (branch_sel),
    .offset     (offset),
    .pc_in      (pc_in),
    .sreg_in    (sreg_in),
    .pc_load    (pc_load),
    .pc_target  (pc_target),
    .busy       (busy),
    .done       (done),
    .taken      (taken),
    .sreg_out   (sreg_out)
);

// file: cbu_branch_unit_tb.sv
// Testbench of the conditional branch unit
`timescale 1ns/1ps
`define CHK(n,e,g) begin num_checks++; if ((e) !== (g)) begin n_errors++; \
 $display("BAD %s exp %h got %h", n, e, g); end end
module cbu_branch_unit_tb;
    logic sys_clk = 0, rst_b = 0, exec_valid = 0, pc_load, busy, done, taken;
    logic [3:0] branch_sel = 0, b;
    logic [6:0] offset = 0, k;
    logic [15:0] pc_in = 0, p, pc_target;
    logic [7:0] sreg_in = 0, s, sreg_out;
    logic [24:0] q[$], n;
    logic pb;
    logic [1:0] lat;
    integer seed = 67, n_errors = 0, num_checks = 0, cyc = 0;
    cbu_branch_unit cbu_branch_unit_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .exec_valid(exec_valid), .branch_sel(branch_sel), .offset(offset),
        .pc_in(pc_in), .sreg_in(sreg_in), .pc_load(pc_load),
        .pc_target(pc_target), .busy(busy), .done(done), .taken(taken),
        .sreg_out(sreg_out));
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Expected outcome of each selector
    function automatic logic cnd(input [3:0] c, input [7:0] f);
        case (c)
            0: return f[0];  1: return !f[0]; 2: return f[2]; 3: return !f[2];
            4: return !(f[2] ^ f[3]); 5: return f[2] ^ f[3];
            6: return f[5];  7: return !f[5]; 8: return f[6]; default: return 0;
        endcase
    endfunction
    task end_of_test;
        if (n_errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Driver issues random branches and notes the outcome
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_b <= 1;
        repeat (400) begin
            @(posedge sys_clk);
            b = {$random(seed)} % 10; s = $random(seed);
            k = $random(seed); p = $random(seed);
            branch_sel <= b; sreg_in <= s; offset <= k; pc_in <= p;
            exec_valid <= 1;
            q.push_back({cnd(b, s), p + {{9{k[6]}}, k} + 16'h0001, s});
            @(posedge sys_clk);
            // A taken branch also meets a refused issue in its second cycle
            if (cnd(b, s)) @(posedge sys_clk);
            exec_valid <= 0;
            repeat (2) @(posedge sys_clk);
        end
        @(posedge sys_clk);
        `CHK("left", 0, q.size())
        end_of_test;
    end
    // Monitor compares each finished branch with the oldest note
    always @(posedge sys_clk) begin
        cyc++;
        pb <= busy;
        lat <= (exec_valid && !busy) ? 2'h1 : lat + 2'h1;
        if (cyc == 3000) begin n_errors++; end_of_test; end
        if (rst_b && done === 1'b1) begin
            n = q.pop_front();
            `CHK("taken", n[24], taken)
            `CHK("load", n[24], pc_load)
            `CHK("flags", n[7:0], sreg_out)
            `CHK("cycles", n[24] ? 2'h2 : 2'h1, lat)
            `CHK("busy", n[24], pb)
            if (n[24]) `CHK("target", n[23:8], pc_target)
        end
    end
endmodule
